/* File: common/sfm_pkg.sv */
// Notes on behaviour
// - logical left shift: bits move up, zero into bit 0, one cycle
// - logical right shift: bits move down, zero into bit 7, one cycle
// - rotate left: old carry into bit 0, old bit 7 into carry
// - rotate right: old carry into bit 7, old bit 0 into carry
// - arithmetic right shift keeps bit 7, shifts the rest down
// - every shift and rotate updates zero, carry, negative, overflow
// - bit store copies source bit b into transfer flag only
// - bit load writes transfer flag into bit b, flags untouched
// - sign flag has one-cycle set and clear, nothing else changes
// - overflow flag has one-cycle set and clear, nothing else changes
// - every status flag has one-cycle set and clear operations
// - load through X then X plus one, two cycles, no flags
// - X minus one first, then load from new X, two cycles
// - load through Y then Y plus one, two cycles
package sfm_pkg;
   localparam int DW = 8;
   localparam int NREG = 32;
   localparam int MEM_AW = 8;
   localparam int MEM_WORDS = 256;
   localparam int BUS_AW = 12;

   // bus map, byte addresses in the low 12 address bits
   localparam logic [11:0] OFS_CMD = 12'h000;
   localparam logic [11:0] OFS_STAT = 12'h004;
   localparam logic [11:0] OFS_STATUS_REGISTER = 12'h008;
   localparam logic [4:0] GPR_PAGE = 5'h02;  // 0x100..0x17C
   localparam logic [1:0] MEM_PAGE = 2'h1;   // 0x400..0x7FC

   // command word fields
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_DST_LSB = 8;
   localparam int CMD_SRC_LSB = 16;
   localparam int CMD_IMM_LSB = 24;

   // status register bit positions
   localparam int SB_C = 0;
   localparam int SB_Z = 1;
   localparam int SB_N = 2;
   localparam int SB_V = 3;
   localparam int SB_S = 4;
   localparam int SB_H = 5;
   localparam int SB_T = 6;
   localparam int SB_I = 7;
   localparam logic [7:0] STATUS_REGISTER_RST = 8'h00;
   localparam int STAT_STATUS_REGISTER_LSB = 8;

   // pointer register pairs
   localparam logic [4:0] X_LO = 5'h1A;
   localparam logic [4:0] X_HI = 5'h1B;
   localparam logic [4:0] Y_LO = 5'h1C;
   localparam logic [4:0] Y_HI = 5'h1D;
   localparam logic [15:0] PTR_STEP = 16'h0001;
   localparam logic [4:0] PAIR_MASK = 5'h1E;
   localparam logic [4:0] PAIR_ODD = 5'h01;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   typedef logic [NREG-1:0][DW-1:0] sfm_gpr_t;

   typedef enum logic [4:0] {
      OP_NOP = 5'h00,
      OP_SHIFT_LEFT_LOGICAL = 5'h01,
      OP_SHIFT_RIGHT_LOGICAL = 5'h02,
      OP_ROTATE_LEFT_CARRY = 5'h03,
      OP_ROTATE_RIGHT_CARRY = 5'h04,
      OP_SHIFT_RIGHT_ARITH = 5'h05,
      OP_NIBBLE_SWAP = 5'h06,
      OP_STATUS_BIT_SET_BY_INDEX = 5'h07,
      OP_STATUS_BIT_CLEAR_BY_INDEX = 5'h08,
      OP_BIT_TO_TRANSFER_FLAG = 5'h09,
      OP_TRANSFER_FLAG_TO_BIT = 5'h0A,
      OP_REGISTER_COPY = 5'h0B,
      OP_REGISTER_PAIR_COPY = 5'h0C,
      OP_IMMEDIATE_LOAD = 5'h0D,
      OP_LOAD_X = 5'h0E,
      OP_LOAD_X_INC = 5'h0F,
      OP_LOAD_X_DEC = 5'h10,
      OP_LOAD_Y = 5'h11,
      OP_LOAD_Y_INC = 5'h12
   } sfm_op_t;

   typedef enum logic {
      EX_IDLE = 1'b0,
      EX_LOAD = 1'b1
   } sfm_exec_t;

   typedef enum logic [1:0] {
      B_IDLE = 2'b00,
      B_DATA = 2'b01,
      B_RESP = 2'b11
   } sfm_bus_t;
endpackage

/* File: common/sfm_mem_if.sv */
// data space port between the executor and its byte memory
interface sfm_mem_if;
   logic en;
   logic we;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;

   modport ctrl (output en, output we, output addr, output wdata,
                 input rdata);
   modport mem (input en, input we, input addr, input wdata,
                output rdata);
endinterface

/* File: logic/sfm_dmem.sv */
// byte memory of the data space, read data registered
module sfm_dmem (
   input wire logic clk,
   input wire logic rst_n,
   sfm_mem_if.mem port
);
   typedef struct packed {
      logic [sfm_pkg::MEM_WORDS-1:0][7:0] cells;
      logic [7:0] rdata;
   } sfm_dmem_st_t;

   sfm_dmem_st_t s_r;
   sfm_dmem_st_t s_nxt;

   // one access per cycle, write or read
   always_comb begin
      s_nxt = s_r;
      if (port.en) begin
         if (port.we) begin
            s_nxt.cells[port.addr] = port.wdata;
         end else begin
            s_nxt.rdata = s_r.cells[port.addr];
         end
      end
   end

   // state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign port.rdata = s_r.rdata;
endmodule

/* File: logic/sfm_exec.sv */
// shift, flag, move and pointer-load executor behind an ahb-lite slave
//
// The AHB-Lite interface to the registers and the register offsets are this design's own decisions.
module sfm_exec (
   input wire logic CLK_SYS,
   input wire logic RESETN,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   output logic BUSY,
   output logic [7:0] STATUS_REGISTER_OUT
);
   typedef struct packed {
      sfm_pkg::sfm_gpr_t regs;
      logic [7:0] status_register;
      sfm_pkg::sfm_exec_t ex;
      logic [4:0] ld_dst;
      sfm_pkg::sfm_bus_t bus;
      logic [11:0] baddr;
      logic bwr;
      logic hready;
      logic hresp;
      logic [31:0] hrdata;
   } sfm_state_t;

   sfm_state_t s_r;
   sfm_state_t s_nxt;
   sfm_mem_if mem_bus ();

   // flags after any shift or rotate: carry is the bit shifted out
   function automatic logic [7:0] sfm_shift_flags(
      input logic [7:0] sr,
      input logic [7:0] res,
      input logic cout
   );
      logic [7:0] o;
      o = sr;
      o[sfm_pkg::SB_C] = cout;
      o[sfm_pkg::SB_Z] = (res == sfm_pkg::BYTE_ZERO);
      o[sfm_pkg::SB_N] = res[7];
      o[sfm_pkg::SB_V] = res[7] ^ cout;
      return o;
   endfunction

   // 16-bit pointer from a register pair
   function automatic logic [15:0] sfm_ptr(
      input sfm_pkg::sfm_gpr_t r,
      input logic [4:0] hi,
      input logic [4:0] lo
   );
      return {r[hi], r[lo]};
   endfunction

   // address window tests on the registered data-phase address
   function automatic logic sfm_is_gpr(input logic [11:0] a);
      return a[11:7] == sfm_pkg::GPR_PAGE;
   endfunction

   function automatic logic sfm_is_mem(input logic [11:0] a);
      return a[11:10] == sfm_pkg::MEM_PAGE;
   endfunction

   // register number carried in a register-window word address
   function automatic logic [4:0] sfm_gpr_idx(input logic [11:0] a);
      return a[6:2];
   endfunction

   // byte number carried in a data-window word address
   function automatic logic [7:0] sfm_mem_idx(input logic [11:0] a);
      return a[9:2];
   endfunction

   sfm_dmem u_dmem (
      .clk(CLK_SYS),
      .rst_n(RESETN),
      .port(mem_bus.mem)
   );

   // bus slave and instruction execution
   always_comb begin
      sfm_pkg::sfm_op_t op;
      logic [4:0] di;
      logic [4:0] si;
      logic [4:0] dp;
      logic [4:0] sp;
      logic [2:0] bi;
      logic [7:0] kv;
      logic [7:0] rd;
      logic [7:0] rr;
      logic [7:0] res;
      logic [15:0] px;
      logic [31:0] rv;
      logic is_gpr;
      logic is_mem;
      s_nxt = s_r;
      op = sfm_pkg::sfm_op_t'(HWDATA[sfm_pkg::CMD_OP_LSB +: 5]);
      di = HWDATA[sfm_pkg::CMD_DST_LSB +: 5];
      si = HWDATA[sfm_pkg::CMD_SRC_LSB +: 5];
      dp = di & sfm_pkg::PAIR_MASK;
      sp = si & sfm_pkg::PAIR_MASK;
      kv = HWDATA[sfm_pkg::CMD_IMM_LSB +: 8];
      bi = kv[2:0];
      rd = s_r.regs[di];
      rr = s_r.regs[si];
      res = rd;
      px = '0;
      rv = '0;
      is_gpr = sfm_is_gpr(s_r.baddr);
      is_mem = sfm_is_mem(s_r.baddr);
      mem_bus.en = 1'b0;
      mem_bus.we = 1'b0;
      mem_bus.addr = '0;
      mem_bus.wdata = '0;

      // second cycle of a pointer load: registered byte into Rd
      if (s_r.ex == sfm_pkg::EX_LOAD) begin
         s_nxt.regs[s_r.ld_dst] = mem_bus.rdata;
         s_nxt.ex = sfm_pkg::EX_IDLE;
      end

      case (s_r.bus)
         sfm_pkg::B_IDLE: begin
            if (HSEL && HTRANS[1] && HREADY) begin
               s_nxt.bus = sfm_pkg::B_DATA;
               s_nxt.baddr = HADDR[11:0];
               s_nxt.bwr = HWRITE;
               s_nxt.hready = 1'b0;
            end
         end
         sfm_pkg::B_DATA: begin
            // data phase waits while a load finishes
            if (s_r.ex == sfm_pkg::EX_IDLE) begin
               if (s_r.bwr) begin
                  s_nxt.bus = sfm_pkg::B_IDLE;
                  s_nxt.hready = 1'b1;
                  if (is_mem) begin
                     mem_bus.en = 1'b1;
                     mem_bus.we = 1'b1;
                     mem_bus.addr = sfm_mem_idx(s_r.baddr);
                     mem_bus.wdata = HWDATA[7:0];
                  end else if (is_gpr) begin
                     s_nxt.regs[sfm_gpr_idx(s_r.baddr)] = HWDATA[7:0];
                  end else if (s_r.baddr == sfm_pkg::OFS_STATUS_REGISTER) begin
                     s_nxt.status_register = HWDATA[7:0];
                  end else if (s_r.baddr == sfm_pkg::OFS_CMD) begin
                     case (op)
                        sfm_pkg::OP_SHIFT_LEFT_LOGICAL: begin
                           res = {rd[6:0], 1'b0};
                           s_nxt.regs[di] = res;
                           s_nxt.status_register = sfm_shift_flags(s_r.status_register, res,
                                                        rd[7]);
                        end
                        sfm_pkg::OP_SHIFT_RIGHT_LOGICAL: begin
                           res = {1'b0, rd[7:1]};
                           s_nxt.regs[di] = res;
                           s_nxt.status_register = sfm_shift_flags(s_r.status_register, res,
                                                        rd[0]);
                        end
                        sfm_pkg::OP_ROTATE_LEFT_CARRY: begin
                           res = {rd[6:0], s_r.status_register[sfm_pkg::SB_C]};
                           s_nxt.regs[di] = res;
                           s_nxt.status_register = sfm_shift_flags(s_r.status_register, res,
                                                        rd[7]);
                        end
                        sfm_pkg::OP_ROTATE_RIGHT_CARRY: begin
                           res = {s_r.status_register[sfm_pkg::SB_C], rd[7:1]};
                           s_nxt.regs[di] = res;
                           s_nxt.status_register = sfm_shift_flags(s_r.status_register, res,
                                                        rd[0]);
                        end
                        sfm_pkg::OP_SHIFT_RIGHT_ARITH: begin
                           res = {rd[7], rd[7:1]};
                           s_nxt.regs[di] = res;
                           s_nxt.status_register = sfm_shift_flags(s_r.status_register, res,
                                                        rd[0]);
                        end
                        sfm_pkg::OP_NIBBLE_SWAP: begin
                           s_nxt.regs[di] = {rd[3:0], rd[7:4]};
                        end
                        sfm_pkg::OP_STATUS_BIT_SET_BY_INDEX: begin
                           // covers carry, zero, negative, overflow, sign,
                           // half carry, transfer and interrupt enable
                           s_nxt.status_register[bi] = 1'b1;
                        end
                        sfm_pkg::OP_STATUS_BIT_CLEAR_BY_INDEX: begin
                           s_nxt.status_register[bi] = 1'b0;
                        end
                        sfm_pkg::OP_BIT_TO_TRANSFER_FLAG: begin
                           s_nxt.status_register[sfm_pkg::SB_T] = rr[bi];
                        end
                        sfm_pkg::OP_TRANSFER_FLAG_TO_BIT: begin
                           res[bi] = s_r.status_register[sfm_pkg::SB_T];
                           s_nxt.regs[di] = res;
                        end
                        sfm_pkg::OP_REGISTER_COPY: begin
                           s_nxt.regs[di] = rr;
                        end
                        sfm_pkg::OP_REGISTER_PAIR_COPY: begin
                           s_nxt.regs[dp] = s_r.regs[sp];
                           s_nxt.regs[dp | sfm_pkg::PAIR_ODD] =
                              s_r.regs[sp | sfm_pkg::PAIR_ODD];
                        end
                        sfm_pkg::OP_IMMEDIATE_LOAD: begin
                           s_nxt.regs[di] = kv;
                        end
                        sfm_pkg::OP_LOAD_X,
                        sfm_pkg::OP_LOAD_X_INC: begin
                           px = sfm_ptr(s_r.regs, sfm_pkg::X_HI,
                                        sfm_pkg::X_LO);
                           mem_bus.en = 1'b1;
                           mem_bus.addr = px[7:0];
                           s_nxt.ex = sfm_pkg::EX_LOAD;
                           s_nxt.ld_dst = di;
                           if (op == sfm_pkg::OP_LOAD_X_INC) begin
                              px = px + sfm_pkg::PTR_STEP;
                              s_nxt.regs[sfm_pkg::X_LO] = px[7:0];
                              s_nxt.regs[sfm_pkg::X_HI] = px[15:8];
                           end
                        end
                        // pointer is stepped back before the read
                        sfm_pkg::OP_LOAD_X_DEC: begin
                           px = sfm_ptr(s_r.regs, sfm_pkg::X_HI,
                                        sfm_pkg::X_LO) - sfm_pkg::PTR_STEP;
                           mem_bus.en = 1'b1;
                           mem_bus.addr = px[7:0];
                           s_nxt.regs[sfm_pkg::X_LO] = px[7:0];
                           s_nxt.regs[sfm_pkg::X_HI] = px[15:8];
                           s_nxt.ex = sfm_pkg::EX_LOAD;
                           s_nxt.ld_dst = di;
                        end
                        sfm_pkg::OP_LOAD_Y,
                        sfm_pkg::OP_LOAD_Y_INC: begin
                           px = sfm_ptr(s_r.regs, sfm_pkg::Y_HI,
                                        sfm_pkg::Y_LO);
                           mem_bus.en = 1'b1;
                           mem_bus.addr = px[7:0];
                           s_nxt.ex = sfm_pkg::EX_LOAD;
                           s_nxt.ld_dst = di;
                           if (op == sfm_pkg::OP_LOAD_Y_INC) begin
                              px = px + sfm_pkg::PTR_STEP;
                              s_nxt.regs[sfm_pkg::Y_LO] = px[7:0];
                              s_nxt.regs[sfm_pkg::Y_HI] = px[15:8];
                           end
                        end
                        default: begin
                           s_nxt.ex = s_r.ex; // no operation
                        end
                     endcase
                  end
               end else begin
                  // read: issue now, answer in the next cycle
                  s_nxt.bus = sfm_pkg::B_RESP;
                  if (is_mem) begin
                     mem_bus.en = 1'b1;
                     mem_bus.addr = sfm_mem_idx(s_r.baddr);
                  end
               end
            end
         end
         sfm_pkg::B_RESP: begin
            // answer from the window named in the address phase
            if (is_mem) begin
               rv[7:0] = mem_bus.rdata;
            end else if (is_gpr) begin
               rv[7:0] = s_r.regs[sfm_gpr_idx(s_r.baddr)];
            end else if (s_r.baddr == sfm_pkg::OFS_STATUS_REGISTER) begin
               rv[7:0] = s_r.status_register;
            end else if (s_r.baddr == sfm_pkg::OFS_STAT) begin
               rv[sfm_pkg::STAT_STATUS_REGISTER_LSB +: 8] = s_r.status_register;
               rv[0] = s_r.ex;
            end
            s_nxt.hrdata = rv;
            s_nxt.hready = 1'b1;
            s_nxt.bus = sfm_pkg::B_IDLE;
         end
         default: begin
            s_nxt.bus = sfm_pkg::B_IDLE;
            s_nxt.hready = 1'b1;
         end
      endcase
   end

   // state register
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         s_r <= '0;
         s_r.status_register <= sfm_pkg::STATUS_REGISTER_RST;
         s_r.hready <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // all outputs straight from the state register
   assign HRDATA = s_r.hrdata;
   assign HREADYOUT = s_r.hready;
   assign HRESP = s_r.hresp; // always okay
   assign BUSY = s_r.ex;
   assign STATUS_REGISTER_OUT = s_r.status_register;
endmodule

/* File: sim/sfm_exec_checker.sv */
// bus-side timing checks on the top ports of the executor
module sfm_exec_checker (
   input wire logic CLK_SYS,
   input wire logic RESETN,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   input wire logic [31:0] HRDATA,
   input wire logic HREADYOUT,
   input wire logic HRESP,
   input wire logic BUSY,
   input wire logic [7:0] STATUS_REGISTER_OUT
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RESETN);
   logic take;
   // a transfer is accepted at this edge
   assign take = HSEL && HTRANS[1] && HREADY;
   chk_write_stall: assert property (take && HWRITE |=> !HREADYOUT)
      else $error("write data phase did not wait");
   chk_read_stall: assert property (
      take && !HWRITE |=> !HREADYOUT[*2])
      else $error("read data phase too short");
   chk_answer_bound: assert property (take |-> ##[2:4] HREADYOUT)
      else $error("no answer within bound");
   chk_busy_single: assert property ($rose(BUSY) |=> !BUSY)
      else $error("busy longer than one cycle");
   chk_busy_after: assert property (
      $rose(BUSY) |-> HREADYOUT && !$past(HREADYOUT))
      else $error("busy not tied to a command commit");
   chk_status_register_commit: assert property (
      $changed(STATUS_REGISTER_OUT) |-> !$past(HREADYOUT))
      else $error("status changed outside a commit");
   chk_rdata_hold: assert property (
      $changed(HRDATA) |-> HREADYOUT && !$past(HREADYOUT))
      else $error("read data moved outside an answer");
   chk_ready_idle: assert property (
      HREADYOUT && !take |=> HREADYOUT)
      else $error("ready dropped with no transfer");
   chk_resp_okay: assert property (!HRESP)
      else $error("error response on the bus");
   cov_write: cover property (take && HWRITE);
   cov_read: cover property (take && !HWRITE);
   cov_load: cover property ($rose(BUSY));
endmodule
bind sfm_exec sfm_exec_checker sfm_exec_checker_i (.CLK_SYS(CLK_SYS),
   .RESETN(RESETN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
   .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY),
   .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .BUSY(BUSY),
   .STATUS_REGISTER_OUT(STATUS_REGISTER_OUT));

/* File: sim/test_shift_flag_move_load_exec.sv */
// command sequences over the bus with computed expectations
module test_shift_flag_move_load_exec;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLK_SYS, RESETN, HSEL, HWRITE, HREADYOUT, HRESP, BUSY;
   logic [31:0] HADDR, HWDATA, HRDATA, q;
   logic [1:0] HTRANS;
   logic [2:0] HSIZE;
   logic [7:0] STATUS_REGISTER_OUT;
   logic [7:0] vals [4] = '{8'h81, 8'h40, 8'h01, 8'h00};
   int errors, tests_run, cycles;
   sfm_exec sfm_exec_i (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .HSEL(HSEL),
      .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
      .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP), .BUSY(BUSY),
      .STATUS_REGISTER_OUT(STATUS_REGISTER_OUT));
   // 50 MHz clock
   initial begin
      CLK_SYS = 1'b0;
      forever #10 CLK_SYS = ~CLK_SYS;
   end
   // hang guard
   always @(posedge CLK_SYS) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         finish_test();
      end
   end
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one single ahb-lite transfer, held until ready is sampled high
   task automatic xfer(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
      HTRANS <= 2'h2;
      HADDR <= {20'h0, a};
      HWRITE <= wr;
      @(posedge CLK_SYS);
      while (HREADYOUT !== 1'b1) @(posedge CLK_SYS);
      HTRANS <= 2'h0;
      HWDATA <= wd;
      @(posedge CLK_SYS);
      while (HREADYOUT !== 1'b1) @(posedge CLK_SYS);
      q = HRDATA;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      xfer(1'b1, a, {24'h0, d});
   endtask
   task automatic rdc(input logic [11:0] a, input logic [7:0] e);
      xfer(1'b0, a, 32'h0);
      cmp(q, {24'h0, e});
   endtask
   task automatic cmd(input logic [4:0] op, input logic [4:0] d,
                      input logic [4:0] rr, input logic [7:0] k);
      xfer(1'b1, sfm_pkg::OFS_CMD, {k, 3'h0, rr, 3'h0, d, 3'h0, op});
   endtask
   task automatic ssr(input logic [7:0] v);
      wr(sfm_pkg::OFS_STATUS_REGISTER, v);
   endtask
   task automatic csr(input logic [7:0] e);
      cmp({24'h0, STATUS_REGISTER_OUT}, {24'h0, e});
   endtask
   // pointer load: busy in the commit cycle, flags kept
   task automatic ld(input logic [4:0] op, input logic [4:0] d,
                     input logic [7:0] e);
      cmd(op, d, 5'h0, 8'h00);
      cmp({31'h0, BUSY}, 32'h1);
      csr(8'hA5);
      rdc(ga(d), e);
   endtask
   function automatic logic [11:0] ga(input logic [4:0] n);
      return 12'h100 + {5'h0, n, 2'h0};
   endfunction
   function automatic logic [11:0] ma(input logic [7:0] n);
      return 12'h400 + {2'h0, n, 2'h0};
   endfunction
   // {carry out, result} of each shift or rotate
   function automatic logic [8:0] shf(input int op, input logic [7:0] v,
                                      input logic c);
      case (op)
         1: return {v, 1'b0};
         2: return {v[0], 1'b0, v[7:1]};
         3: return {v, c};
         4: return {v[0], c, v[7:1]};
         default: return {v[0], v[7], v[7:1]};
      endcase
   endfunction
   // one shift or rotate case: operand v, carry in c
   task automatic shift_case(input int op, input logic [7:0] v,
                             input logic c);
      logic [7:0] s;
      logic [8:0] r;
      s = c ? 8'hFF : 8'h50;
      r = shf(op, v, c);
      wr(ga(5'(op + 8)), v);
      ssr(s);
      cmd(5'(op), 5'(op + 8), 5'h0, 8'h00);
      rdc(ga(5'(op + 8)), r[7:0]);
      csr({s[7:4], r[7] ^ r[8], r[7], r[7:0] == 8'h0, r[8]});
   endtask
   // main sequence
   initial begin
      RESETN = 1'b0;
      HSEL = 1'b1;
      HTRANS = 2'h0;
      HADDR = 32'h0;
      HWRITE = 1'b0;
      HSIZE = 3'h2;
      HWDATA = 32'h0;
      repeat (8) @(posedge CLK_SYS);
      RESETN <= 1'b1;
      @(posedge CLK_SYS);
      csr(8'h00);
      rdc(sfm_pkg::OFS_STAT, 8'h00);
      rdc(ga(5'h1F), 8'h00);
      rdc(ma(8'hFF), 8'h00);
      wr(12'h080, 8'hFF);
      rdc(12'h080, 8'h00);
      cmd(5'h1F, 5'h0, 5'h0, 8'hFF);
      rdc(ga(5'h0), 8'h00);
      csr(8'h00);
      for (int op = 1; op <= 5; op++) begin
         for (int i = 0; i < 4; i++) begin
            for (int c = 0; c < 2; c++) begin
               shift_case(op, vals[i], c[0]);
            end
         end
      end
      for (int b = 0; b < 8; b++) begin
         ssr(8'h00);
         cmd(5'h07, 5'h0, 5'h0, 8'(b));
         csr(8'h01 << b);
         ssr(8'hFF);
         cmd(5'h08, 5'h0, 5'h0, 8'(b));
         csr(~(8'h01 << b));
      end
      rdc(sfm_pkg::OFS_STATUS_REGISTER, 8'h7F);
      wr(ga(5'h06), 8'hA5);
      ssr(8'h3C);
      cmd(5'h06, 5'h06, 5'h0, 8'h00);
      rdc(ga(5'h06), 8'h5A);
      csr(8'h3C);
      ssr(8'hBF);
      wr(ga(5'h07), 8'h20);
      cmd(5'h09, 5'h0, 5'h07, 8'h05);
      csr(8'hFF);
      wr(ga(5'h0B), 8'hF7);
      cmd(5'h0A, 5'h0B, 5'h0, 8'h03);
      rdc(ga(5'h0B), 8'hFF);
      cmd(5'h09, 5'h0, 5'h07, 8'h04);
      csr(8'hBF);
      cmd(5'h0A, 5'h0B, 5'h0, 8'h07);
      rdc(ga(5'h0B), 8'h7F);
      csr(8'hBF);
      wr(ga(5'h03), 8'h77);
      cmd(5'h0B, 5'h0A, 5'h03, 8'h00);
      rdc(ga(5'h0A), 8'h77);
      wr(ga(5'h04), 8'h12);
      wr(ga(5'h05), 8'h34);
      cmd(5'h0C, 5'h09, 5'h05, 8'h00);
      rdc(ga(5'h08), 8'h12);
      rdc(ga(5'h09), 8'h34);
      cmd(5'h0D, 5'h14, 5'h0, 8'hC3);
      rdc(ga(5'h14), 8'hC3);
      csr(8'hBF);
      wr(ma(8'h10), 8'hA1);
      wr(ma(8'h11), 8'hB2);
      wr(ma(8'h0F), 8'hC3);
      wr(ma(8'hFF), 8'h5E);
      wr(ga(5'h1A), 8'h10);
      wr(ga(5'h1B), 8'h00);
      ssr(8'hA5);
      ld(5'h0E, 5'h01, 8'hA1);
      ld(5'h0F, 5'h02, 8'hA1);
      rdc(ga(5'h1A), 8'h11);
      ld(5'h0E, 5'h03, 8'hB2);
      ld(5'h10, 5'h04, 8'hA1);
      ld(5'h10, 5'h05, 8'hC3);
      rdc(ga(5'h1A), 8'h0F);
      wr(ga(5'h1A), 8'h00);
      wr(ga(5'h1B), 8'h01);
      ld(5'h10, 5'h06, 8'h5E);
      rdc(ga(5'h1A), 8'hFF);
      rdc(ga(5'h1B), 8'h00);
      wr(ga(5'h1C), 8'hFF);
      wr(ga(5'h1D), 8'h00);
      ld(5'h11, 5'h07, 8'h5E);
      ld(5'h12, 5'h08, 8'h5E);
      rdc(ga(5'h1C), 8'h00);
      rdc(ga(5'h1D), 8'h01);
      finish_test();
   end
endmodule
